// [inc/sgp_link_if.sv]
// link between encoder end and decoder end: parameter set handshake and slice pixel stream
`timescale 1ns/10ps
interface sgp_link_if;
   sgp_pkg::sgp_pps_t picture_parameter_set;
   logic pps_valid;
   logic pps_ack;
   logic pps_nak;
   logic vbr_cap;
   logic px_valid;
   logic [sgp_pkg::PIX_W-1:0] px_data;
   modport enc (
      output picture_parameter_set,
      output pps_valid,
      input pps_ack,
      input pps_nak,
      input vbr_cap,
      output px_valid,
      output px_data
   );
   modport dec (
      input picture_parameter_set,
      input pps_valid,
      output pps_ack,
      output pps_nak,
      output vbr_cap,
      input px_valid,
      input px_data
   );
endinterface : sgp_link_if

// [inc/sgp_pkg.sv]
// slice geometry package: field widths, register map, error codes, parameter set type
package sgp_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BPP_W = 10;
   localparam int DIM_W = 16;
   localparam int PIX_W = 16;
   localparam int BPC_W = 5;
   // ****************************************
   // rate floor in sixteenths of a bit per pixel, and reset depth in bits per component
   // ****************************************
   localparam logic [9:0] BPP_MIN = 10'h060;
   localparam logic [4:0] BPC_RST = 5'h08;
   // ****************************************
   // register byte offsets of the encoder end
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BPP = 8'h04;
   localparam logic [7:0] REG_PIC_H = 8'h08;
   localparam logic [7:0] REG_PIC_W = 8'h0c;
   localparam logic [7:0] REG_SLICE_H = 8'h10;
   localparam logic [7:0] REG_SLICE_W = 8'h14;
   localparam logic [7:0] REG_DEPTH = 8'h18;
   localparam logic [7:0] REG_RATE_MAX = 8'h1c;
   localparam logic [7:0] REG_STATUS = 8'h20;
   // ****************************************
   // control and status bit positions
   // ****************************************
   localparam int CTRL_START = 0;
   localparam int CTRL_VBR = 1;
   localparam int CTRL_SIMPLE_422 = 2;
   localparam int CTRL_NATIVE_422 = 3;
   localparam int CTRL_NATIVE_420 = 4;
   localparam int CTRL_CONVERT_RGB = 5;
   localparam int CTRL_LINK_VBR = 6;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_LOCAL_ERR = 2;
   localparam int STAT_REFUSED = 3;
   localparam int STAT_ERR_LSB = 4;
   // ****************************************
   // legality error code bits
   // ****************************************
   localparam int ERR_W = 7;
   localparam int ERR_BPP_LOW = 0;
   localparam int ERR_VBR = 1;
   localparam int ERR_RATE = 2;
   localparam int ERR_H_ODD = 3;
   localparam int ERR_W_ODD = 4;
   localparam int ERR_ZERO = 5;
   localparam int ERR_SIMPLE = 6;

   typedef struct packed {
      logic vbr;
      logic simple_422;
      logic native_422;
      logic native_420;
      logic convert_rgb;
      logic [BPC_W-1:0] bpc;
      logic [BPP_W-1:0] bpp;
      logic [DIM_W-1:0] pic_h;
      logic [DIM_W-1:0] pic_w;
      logic [DIM_W-1:0] slice_h;
      logic [DIM_W-1:0] slice_w;
   } sgp_pps_t;

   localparam sgp_pps_t PPS_RST = '{bpc: BPC_RST, default: '0};
endpackage : sgp_pkg

// [verif/sgp_link_properties.sv]
// concurrent checks on the link between the encoder end and the decoder end
`timescale 1ns/10ps
module sgp_link_properties (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire sgp_pkg::sgp_pps_t picture_parameter_set,
   input wire logic pps_valid,
   input wire logic pps_ack,
   input wire logic pps_nak,
   input wire logic vbr_cap,
   input wire logic px_valid,
   input wire logic [sgp_pkg::PIX_W-1:0] px_data
);
   // ****************************************
   // helper: link pixels seen against the padded picture size
   // ****************************************
   logic [31:0] seen_r;
   logic [31:0] want_r;

   function automatic logic [31:0] padded(input logic [15:0] full, input logic [15:0] part);
      padded = ((32'(full) + 32'(part) - 32'h1) / 32'(part)) * 32'(part);
   endfunction : padded

   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         seen_r <= 32'h0;
      end else if (pps_ack) begin
         seen_r <= 32'h0;
      end else if (px_valid) begin
         seen_r <= seen_r + 32'h1;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         want_r <= 32'h0;
      end else if (pps_ack) begin
         want_r <= padded(picture_parameter_set.pic_w, picture_parameter_set.slice_w) * padded(picture_parameter_set.pic_h, picture_parameter_set.slice_h);
      end
   end

   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RESET_I);

   a_answer_two_later: assert property (pps_valid |-> ##2 (pps_ack ^ pps_nak))
      else $error("parameter set not answered two cycles after announce");
   a_answer_only_asked: assert property ((pps_ack || pps_nak) |-> $past(pps_valid, 2))
      else $error("answer without an announce");
   a_low_rate_nak: assert property (pps_valid && picture_parameter_set.bpp < sgp_pkg::BPP_MIN |-> ##2 pps_nak)
      else $error("rate below six bits per pixel accepted");
   a_vbr_nocap_nak: assert property (pps_valid && picture_parameter_set.vbr && !vbr_cap |-> ##2 pps_nak)
      else $error("variable rate accepted without capability");
   a_odd_height_nak: assert property (pps_valid && picture_parameter_set.native_420 && picture_parameter_set.slice_h[0]
      |-> ##2 pps_nak)
      else $error("odd slice height accepted in native 420");
   a_odd_width_nak: assert property (pps_valid && picture_parameter_set.slice_w[0]
      && (picture_parameter_set.simple_422 || picture_parameter_set.native_422 || picture_parameter_set.native_420) |-> ##2 pps_nak)
      else $error("odd slice width accepted in chroma mode");
   a_sent_rate_legal: assert property (pps_valid |-> picture_parameter_set.bpp >= sgp_pkg::BPP_MIN)
      else $error("announced rate below six bits per pixel");
   a_sent_even_width: assert property (pps_valid && (picture_parameter_set.simple_422
      || picture_parameter_set.native_422 || picture_parameter_set.native_420) |-> !picture_parameter_set.slice_w[0])
      else $error("odd slice width announced in chroma mode");
   a_set_steady: assert property (px_valid |-> $stable(picture_parameter_set))
      else $error("parameter set changed during the picture");
   a_stream_start: assert property (pps_ack |-> ##4 px_valid)
      else $error("pixel stream did not start after accept");
   a_padded_count: assert property ($fell(px_valid) |-> seen_r == want_r)
      else $error("link pixel count differs from padded picture size");

   c_accept: cover property (pps_ack);
   c_refuse: cover property (pps_nak);
   c_picture_end: cover property ($fell(px_valid));
endmodule : sgp_link_properties

// [verif/test_picture_slice_geometry_params.sv]
// bench for the parameter set link: register runs, link and user side monitors
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
   $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module test_picture_slice_geometry_params;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [31:0] rdata;
   logic pix_req;
   logic [15:0] pix_x;
   logic [15:0] pix_y;
   logic [15:0] pix_in = 16'h0;
   logic vbr_cap_in = 1'b0;
   logic [9:0] rate_max_in = 10'h3ff;
   logic pps_ok;
   logic [6:0] pps_err;
   logic dv;
   logic [15:0] dd;
   logic [15:0] dx;
   logic [15:0] dy;
   logic fdone;
   logic cap_drop = 1'b0;
   int err_total = 0;
   int comparisons = 0;
   int n_valid = 0;
   int n_real = 0;
   int n_done = 0;
   logic [15:0] link_q[$];
   logic [31:0] d;
   logic [7:0] regs[8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
   logic [31:0] masks[8] = '{32'h3ff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'h1f,
      32'h3ff, 32'h0};

   sgp_link_if sgp_link_if_i ();
   sgp_enc sgp_enc_i (.CLK_SYS_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .PIX_REQ_O(pix_req),
      .PIX_X_O(pix_x), .PIX_Y_O(pix_y), .PIX_DATA_I(pix_in), .link(sgp_link_if_i));
   sgp_dec sgp_dec_i (.CLK_SYS_I(clk), .RESET_I(rst), .VBR_CAP_I(vbr_cap_in),
      .RATE_MAX_I(rate_max_in), .PPS_OK_O(pps_ok), .PPS_ERR_O(pps_err), .PIX_VALID_O(dv),
      .PIX_DATA_O(dd), .PIX_X_O(dx), .PIX_Y_O(dy), .FRAME_DONE_O(fdone), .link(sgp_link_if_i));
   sgp_link_properties sgp_link_properties_i (.CLK_SYS_I(clk), .RESET_I(rst),
      .picture_parameter_set(sgp_link_if_i.picture_parameter_set), .pps_valid(sgp_link_if_i.pps_valid),
      .pps_ack(sgp_link_if_i.pps_ack), .pps_nak(sgp_link_if_i.pps_nak),
      .vbr_cap(sgp_link_if_i.vbr_cap), .px_valid(sgp_link_if_i.px_valid),
      .px_data(sgp_link_if_i.px_data));

   always #2.5 clk = ~clk;

   function automatic logic [15:0] pel(input logic [15:0] x, input logic [15:0] y);
      pel = {y[7:0], x[7:0]};
   endfunction : pel

   // ****************************************
   // user pixel source and link monitors
   // ****************************************
   always @(posedge clk) begin
      if (pix_req) begin
         pix_in <= pel(pix_x, pix_y);
      end
      if (sgp_link_if_i.pps_valid) begin
         n_valid++;
      end
      if (sgp_link_if_i.px_valid) begin
         link_q.push_back(sgp_link_if_i.px_data);
      end
      if (fdone) begin
         n_done++;
      end
      if (dv) begin
         n_real++;
         `CHK("decoder pixel", pel(dx, dy), dd)
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      v = rdata;
   endtask : rd

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // want holds status bits code, refused and local error
   task automatic run(input logic [6:0] ctl, input logic [9:0] bpp, input logic [15:0] ph,
         input logic [15:0] pw, input logic [15:0] sh, input logic [15:0] sw,
         input logic [4:0] bpc, input logic [9:0] cap, input logic [8:0] want);
      logic [31:0] st;
      logic [15:0] ev;
      int i;
      wr(sgp_pkg::REG_BPP, {22'h0, bpp});
      wr(sgp_pkg::REG_PIC_H, {16'h0, ph});
      wr(sgp_pkg::REG_PIC_W, {16'h0, pw});
      wr(sgp_pkg::REG_SLICE_H, {16'h0, sh});
      wr(sgp_pkg::REG_SLICE_W, {16'h0, sw});
      wr(sgp_pkg::REG_DEPTH, {27'h0, bpc});
      wr(sgp_pkg::REG_RATE_MAX, {22'h0, cap});
      link_q.delete();
      n_valid = 0;
      n_real = 0;
      n_done = 0;
      wr(sgp_pkg::REG_CTRL, {25'h0, ctl} | 32'h1);
      // capability drops after the local check, so only the far end can refuse
      if (cap_drop) vbr_cap_in <= 1'b0;
      repeat (4) @(posedge clk);
      for (i = 0; i < 400; i++) begin
         rd(sgp_pkg::REG_STATUS, st);
         if (st[sgp_pkg::STAT_BUSY] === 1'b0) break;
      end
      repeat (4) @(posedge clk);
      `CHK("status flags", want, want[1] ? {7'h0, st[3:2]} : st[10:2])
      `CHK("announce count", want[0] ? 0 : 1, n_valid)
      i = 0;
      if (want === 9'h0) begin
         `CHK("done flag", 1'b1, st[sgp_pkg::STAT_DONE])
         `CHK("decoder ok", 1'b1, pps_ok)
         `CHK("frame done count", 1, n_done)
         `CHK("real pixels", int'(pw) * int'(ph), n_real)
         for (int sy = 0; sy < ph; sy += sh) for (int sx = 0; sx < pw; sx += sw)
            for (int r = 0; r < sh; r++) for (int c = 0; c < sw; c++) begin
               ev = (sy + r >= ph) ? 16'h1 << (bpc - 5'h1)
                  : pel(16'((sx + c < pw) ? sx + c : pw - 1), 16'(sy + r));
               `CHK("link pixel", ev, (i < link_q.size()) ? link_q[i] : 16'hxxxx)
               i++;
            end
      end
      `CHK("link pixel count", i, link_q.size())
   endtask : run

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(sgp_pkg::REG_DEPTH, d);
      `CHK("depth reset", 32'h8, d)
      for (int k = 0; k < 8; k++) begin
         wr(regs[k], 32'hffffffff);
         rd(regs[k], d);
         `CHK("register readback", masks[k], d)
      end
      run(7'h00, 10'h060, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h3ff, 9'h000);
      run(7'h00, 10'h05f, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h3ff, 9'h005);
      run(7'h00, 10'h3ff, 16'd4, 16'd4, 16'd2, 16'd2, 5'd10, 10'h3ff, 9'h000);
      run(7'h02, 10'h3ff, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h100, 9'h009);
      vbr_cap_in <= 1'b1;
      run(7'h42, 10'h3ff, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h100, 9'h000);
      run(7'h00, 10'h101, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h100, 9'h011);
      run(7'h10, 10'h200, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h100, 9'h000);
      run(7'h08, 10'h201, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h100, 9'h011);
      run(7'h10, 10'h200, 16'd3, 16'd5, 16'd3, 16'd2, 5'd8, 10'h100, 9'h021);
      run(7'h04, 10'h060, 16'd3, 16'd5, 16'd2, 16'd3, 5'd8, 10'h3ff, 9'h041);
      rate_max_in <= 10'h060;
      run(7'h00, 10'h100, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h3ff, 9'h002);
      `CHK("decoder ok", 1'b0, pps_ok)
      `CHK("decoder code", 7'h04, pps_err)
      cap_drop = 1'b1;
      run(7'h42, 10'h3ff, 16'd3, 16'd5, 16'd2, 16'd2, 5'd8, 10'h3ff, 9'h002);
      `CHK("decoder code", 7'h02, pps_err)
      test_done();
   end

   initial begin
      #200000;
      err_total++;
      test_done();
   end
endmodule : test_picture_slice_geometry_params

// [verilog/sgp_chk.sv]
// parameter set legality checker shared by both ends
`timescale 1ns/10ps
module sgp_chk (
   input wire sgp_pkg::sgp_pps_t pps_i,
   input wire logic vbr_cap_i,
   input wire logic [sgp_pkg::BPP_W-1:0] rate_max_i,
   output logic [sgp_pkg::ERR_W-1:0] err_o
);
   logic [sgp_pkg::BPP_W:0] limit;
   logic nat;

   assign nat = pps_i.native_422 | pps_i.native_420;
   // doubled field under native modes, so the limit doubles too
   assign limit = nat ? {rate_max_i, 1'b0} : {1'b0, rate_max_i};

   always_comb begin
      err_o = '0;
      err_o[sgp_pkg::ERR_BPP_LOW] = pps_i.bpp < sgp_pkg::BPP_MIN;
      err_o[sgp_pkg::ERR_VBR] = pps_i.vbr & ~vbr_cap_i;
      err_o[sgp_pkg::ERR_RATE] = ~pps_i.vbr & ({1'b0, pps_i.bpp} > limit);
      err_o[sgp_pkg::ERR_H_ODD] = pps_i.native_420 & pps_i.slice_h[0];
      err_o[sgp_pkg::ERR_W_ODD] = (pps_i.simple_422 | nat) & pps_i.slice_w[0];
      err_o[sgp_pkg::ERR_ZERO] = (pps_i.pic_h == '0) | (pps_i.pic_w == '0)
         | (pps_i.slice_h == '0) | (pps_i.slice_w == '0);
      err_o[sgp_pkg::ERR_SIMPLE] = pps_i.simple_422 & nat;
   end
endmodule : sgp_chk

// [verilog/sgp_dec.sv]
// decoder end: parameter set acceptance and removal of slice padding
`timescale 1ns/10ps
module sgp_dec (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire logic VBR_CAP_I,
   input wire logic [sgp_pkg::BPP_W-1:0] RATE_MAX_I,
   output logic PPS_OK_O,
   output logic [sgp_pkg::ERR_W-1:0] PPS_ERR_O,
   output logic PIX_VALID_O,
   output logic [sgp_pkg::PIX_W-1:0] PIX_DATA_O,
   output logic [sgp_pkg::DIM_W-1:0] PIX_X_O,
   output logic [sgp_pkg::DIM_W-1:0] PIX_Y_O,
   output logic FRAME_DONE_O,
   sgp_link_if.dec link
);
   sgp_pkg::sgp_pps_t pps_r;
   logic [sgp_pkg::ERR_W-1:0] err_c;
   logic chk_r;
   logic ack_r;
   logic nak_r;
   logic cap_r;
   logic [sgp_pkg::DIM_W-1:0] ox_r;
   logic [sgp_pkg::DIM_W-1:0] oy_r;
   logic [sgp_pkg::DIM_W-1:0] x_r;
   logic [sgp_pkg::DIM_W-1:0] y_r;
   logic [sgp_pkg::DIM_W:0] px;
   logic [sgp_pkg::DIM_W:0] py;
   logic row_end;
   logic slice_end;
   logic last_col;
   logic last_row;

   sgp_chk u_chk (
      .pps_i(pps_r),
      .vbr_cap_i(cap_r),
      .rate_max_i(RATE_MAX_I),
      .err_o(err_c)
   );

   // ****************************************
   // parameter set handshake
   // ****************************************
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         pps_r <= sgp_pkg::PPS_RST;
         chk_r <= 1'b0;
         ack_r <= 1'b0;
         nak_r <= 1'b0;
         cap_r <= 1'b0;
         PPS_OK_O <= 1'b0;
         PPS_ERR_O <= '0;
      end else begin
         cap_r <= VBR_CAP_I;
         if (link.pps_valid) pps_r <= link.picture_parameter_set;
         chk_r <= link.pps_valid;
         ack_r <= chk_r & (err_c == '0);
         nak_r <= chk_r & (err_c != '0);
         if (chk_r) begin
            PPS_OK_O <= err_c == '0;
            PPS_ERR_O <= err_c;
         end
      end
   end

   assign link.pps_ack = ack_r;
   assign link.pps_nak = nak_r;
   assign link.vbr_cap = cap_r;

   // ****************************************
   // slice walk, same grid as the encoder
   // ****************************************
   assign px = {1'b0, ox_r} + {1'b0, x_r};
   assign py = {1'b0, oy_r} + {1'b0, y_r};
   assign row_end = x_r == pps_r.slice_w - 16'h0001;
   assign slice_end = row_end & (y_r == pps_r.slice_h - 16'h0001);
   assign last_col = ({1'b0, ox_r} + {1'b0, pps_r.slice_w}) >= {1'b0, pps_r.pic_w};
   assign last_row = ({1'b0, oy_r} + {1'b0, pps_r.slice_h}) >= {1'b0, pps_r.pic_h};

   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         ox_r <= '0;
         oy_r <= '0;
         x_r <= '0;
         y_r <= '0;
      end else if (link.pps_valid) begin
         ox_r <= '0;
         oy_r <= '0;
         x_r <= '0;
         y_r <= '0;
      end else if (link.px_valid) begin
         if (slice_end) begin
            x_r <= '0;
            y_r <= '0;
            ox_r <= last_col ? '0 : ox_r + pps_r.slice_w;
            oy_r <= last_col ? oy_r + pps_r.slice_h : oy_r;
         end else if (row_end) begin
            x_r <= '0;
            y_r <= y_r + 16'h0001;
         end else begin
            x_r <= x_r + 16'h0001;
         end
      end
   end

   // padded rows and columns are consumed but not shown
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         PIX_VALID_O <= 1'b0;
         PIX_DATA_O <= '0;
         PIX_X_O <= '0;
         PIX_Y_O <= '0;
         FRAME_DONE_O <= 1'b0;
      end else begin
         PIX_VALID_O <= link.px_valid & (py < {1'b0, pps_r.pic_h})
            & (px < {1'b0, pps_r.pic_w});
         PIX_DATA_O <= link.px_data;
         PIX_X_O <= px[15:0];
         PIX_Y_O <= py[15:0];
         FRAME_DONE_O <= link.px_valid & slice_end & last_col & last_row;
      end
   end
endmodule : sgp_dec

// [verilog/sgp_enc.sv]
// encoder end: parameter set registers, legality gate and padded slice pixel stream
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
// Function
// - variable rate only if link and decoder allow
// - rate field: ten bits, sixteenths per pixel
// - reject rates below six bits per pixel
// - fixed rate capped by sustained midpoint rate
// - native chroma modes carry doubled rate
// - accept any field value up to 63.9375
// - picture height is sixteen bit rows
// - picture width is sixteen bit columns
// - picture should be near slice multiples
// - slice height and width sixteen bits
// - one slice size for whole picture
// - pad bottom slices with midpoint rows
// - pad right slices repeating last column
// - transport carries padded pixels too
// - slice dimensions even in chroma modes; code checks height only in native 420, width in all three
module sgp_enc (
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire logic [sgp_pkg::ADDR_W-1:0] REG_ADDR_I,
   input wire logic [sgp_pkg::DATA_W-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [sgp_pkg::DATA_W-1:0] REG_RDATA_O,
   output logic PIX_REQ_O,
   output logic [sgp_pkg::DIM_W-1:0] PIX_X_O,
   output logic [sgp_pkg::DIM_W-1:0] PIX_Y_O,
   input wire logic [sgp_pkg::PIX_W-1:0] PIX_DATA_I,
   sgp_link_if.enc link
);
   typedef enum logic [1:0] {IDLE, ANNOUNCE, WAIT, STREAM} sgp_enc_state_t;

   sgp_enc_state_t state_r;
   sgp_pkg::sgp_pps_t pps_r;
   logic link_vbr_r;
   logic [sgp_pkg::BPP_W-1:0] rate_max_r;
   logic start_r;
   logic done_r;
   logic lerr_r;
   logic nak_r;
   logic [sgp_pkg::ERR_W-1:0] code_r;
   logic [sgp_pkg::ERR_W-1:0] err_c;
   logic [sgp_pkg::DIM_W-1:0] ox_r;
   logic [sgp_pkg::DIM_W-1:0] oy_r;
   logic [sgp_pkg::DIM_W-1:0] x_r;
   logic [sgp_pkg::DIM_W-1:0] y_r;
   logic [1:0] pend_r;
   logic [1:0] pend_pad_r;
   logic pps_valid_r;
   logic px_valid_r;
   logic [sgp_pkg::PIX_W-1:0] px_data_r;
   logic [sgp_pkg::DIM_W:0] px;
   logic [sgp_pkg::DIM_W:0] py;
   logic pad_row;
   logic [sgp_pkg::DIM_W-1:0] col;
   logic row_end;
   logic slice_end;
   logic last_col;
   logic last_row;
   logic pic_end;
   logic [sgp_pkg::PIX_W-1:0] midpoint;
   logic wr_ok;

   // ****************************************
   // legality check
   // ****************************************
   sgp_chk u_chk (
      .pps_i(pps_r),
      .vbr_cap_i(link_vbr_r & link.vbr_cap),
      .rate_max_i(rate_max_r),
      .err_o(err_c)
   );

   // ****************************************
   // register writes
   // ****************************************
   // parameters are frozen while a picture is in flight
   assign wr_ok = REG_WR_I & (state_r == IDLE);

   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         pps_r <= sgp_pkg::PPS_RST;
         link_vbr_r <= 1'b0;
         rate_max_r <= '0;
      end else if (wr_ok) begin
         unique case (REG_ADDR_I)
            sgp_pkg::REG_CTRL: begin
               pps_r.vbr <= REG_WDATA_I[sgp_pkg::CTRL_VBR];
               pps_r.simple_422 <= REG_WDATA_I[sgp_pkg::CTRL_SIMPLE_422];
               pps_r.native_422 <= REG_WDATA_I[sgp_pkg::CTRL_NATIVE_422];
               pps_r.native_420 <= REG_WDATA_I[sgp_pkg::CTRL_NATIVE_420];
               pps_r.convert_rgb <= REG_WDATA_I[sgp_pkg::CTRL_CONVERT_RGB];
               link_vbr_r <= REG_WDATA_I[sgp_pkg::CTRL_LINK_VBR];
            end
            sgp_pkg::REG_BPP: pps_r.bpp <= REG_WDATA_I[sgp_pkg::BPP_W-1:0];
            sgp_pkg::REG_PIC_H: pps_r.pic_h <= REG_WDATA_I[sgp_pkg::DIM_W-1:0];
            sgp_pkg::REG_PIC_W: pps_r.pic_w <= REG_WDATA_I[sgp_pkg::DIM_W-1:0];
            sgp_pkg::REG_SLICE_H: pps_r.slice_h <= REG_WDATA_I[sgp_pkg::DIM_W-1:0];
            sgp_pkg::REG_SLICE_W: pps_r.slice_w <= REG_WDATA_I[sgp_pkg::DIM_W-1:0];
            sgp_pkg::REG_DEPTH: pps_r.bpc <= REG_WDATA_I[sgp_pkg::BPC_W-1:0];
            sgp_pkg::REG_RATE_MAX: rate_max_r <= REG_WDATA_I[sgp_pkg::BPP_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         start_r <= 1'b0;
      end else begin
         start_r <= wr_ok & (REG_ADDR_I == sgp_pkg::REG_CTRL)
            & REG_WDATA_I[sgp_pkg::CTRL_START];
      end
   end

   // ****************************************
   // register reads
   // ****************************************
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         REG_RDATA_O <= '0;
      end else if (REG_RD_I) begin
         REG_RDATA_O <= '0;
         unique case (REG_ADDR_I)
            sgp_pkg::REG_CTRL: begin
               REG_RDATA_O[sgp_pkg::CTRL_VBR] <= pps_r.vbr;
               REG_RDATA_O[sgp_pkg::CTRL_SIMPLE_422] <= pps_r.simple_422;
               REG_RDATA_O[sgp_pkg::CTRL_NATIVE_422] <= pps_r.native_422;
               REG_RDATA_O[sgp_pkg::CTRL_NATIVE_420] <= pps_r.native_420;
               REG_RDATA_O[sgp_pkg::CTRL_CONVERT_RGB] <= pps_r.convert_rgb;
               REG_RDATA_O[sgp_pkg::CTRL_LINK_VBR] <= link_vbr_r;
            end
            sgp_pkg::REG_BPP: REG_RDATA_O[sgp_pkg::BPP_W-1:0] <= pps_r.bpp;
            sgp_pkg::REG_PIC_H: REG_RDATA_O[sgp_pkg::DIM_W-1:0] <= pps_r.pic_h;
            sgp_pkg::REG_PIC_W: REG_RDATA_O[sgp_pkg::DIM_W-1:0] <= pps_r.pic_w;
            sgp_pkg::REG_SLICE_H: REG_RDATA_O[sgp_pkg::DIM_W-1:0] <= pps_r.slice_h;
            sgp_pkg::REG_SLICE_W: REG_RDATA_O[sgp_pkg::DIM_W-1:0] <= pps_r.slice_w;
            sgp_pkg::REG_DEPTH: REG_RDATA_O[sgp_pkg::BPC_W-1:0] <= pps_r.bpc;
            sgp_pkg::REG_RATE_MAX: REG_RDATA_O[sgp_pkg::BPP_W-1:0] <= rate_max_r;
            sgp_pkg::REG_STATUS: begin
               REG_RDATA_O[sgp_pkg::STAT_BUSY] <= state_r != IDLE;
               REG_RDATA_O[sgp_pkg::STAT_DONE] <= done_r;
               REG_RDATA_O[sgp_pkg::STAT_LOCAL_ERR] <= lerr_r;
               REG_RDATA_O[sgp_pkg::STAT_REFUSED] <= nak_r;
               REG_RDATA_O[sgp_pkg::STAT_ERR_LSB +: sgp_pkg::ERR_W] <= code_r;
            end
            default: ;
         endcase
      end
   end

   // ****************************************
   // slice walk
   // ****************************************
   assign px = {1'b0, ox_r} + {1'b0, x_r};
   assign py = {1'b0, oy_r} + {1'b0, y_r};
   assign pad_row = py >= {1'b0, pps_r.pic_h};
   assign col = (px >= {1'b0, pps_r.pic_w}) ? pps_r.pic_w - 16'h0001 : px[15:0];
   assign row_end = x_r == pps_r.slice_w - 16'h0001;
   assign slice_end = row_end & (y_r == pps_r.slice_h - 16'h0001);
   assign last_col = ({1'b0, ox_r} + {1'b0, pps_r.slice_w}) >= {1'b0, pps_r.pic_w};
   assign last_row = ({1'b0, oy_r} + {1'b0, pps_r.slice_h}) >= {1'b0, pps_r.pic_h};
   assign pic_end = slice_end & last_col & last_row;
   assign midpoint = sgp_pkg::PIX_W'(16'h0001 << (pps_r.bpc - 5'h01));

   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         state_r <= IDLE;
      end else begin
         unique case (state_r)
            IDLE: if (start_r) state_r <= (err_c == '0) ? ANNOUNCE : IDLE;
            ANNOUNCE: state_r <= WAIT;
            WAIT: begin
               if (link.pps_ack) state_r <= STREAM;
               else if (link.pps_nak) state_r <= IDLE;
            end
            STREAM: if (pic_end) state_r <= IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         ox_r <= '0;
         oy_r <= '0;
         x_r <= '0;
         y_r <= '0;
      end else if (state_r != STREAM) begin
         ox_r <= '0;
         oy_r <= '0;
         x_r <= '0;
         y_r <= '0;
      end else if (slice_end) begin
         x_r <= '0;
         y_r <= '0;
         ox_r <= last_col ? '0 : ox_r + pps_r.slice_w;
         oy_r <= last_col ? oy_r + pps_r.slice_h : oy_r;
      end else if (row_end) begin
         x_r <= '0;
         y_r <= y_r + 16'h0001;
      end else begin
         x_r <= x_r + 16'h0001;
      end
   end

   // ****************************************
   // pixel fetch and link drive
   // ****************************************
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         PIX_REQ_O <= 1'b0;
         PIX_X_O <= '0;
         PIX_Y_O <= '0;
         pend_r <= '0;
         pend_pad_r <= '0;
      end else begin
         PIX_REQ_O <= (state_r == STREAM) & ~pad_row;
         PIX_X_O <= col;
         PIX_Y_O <= py[15:0];
         pend_r <= {pend_r[0], state_r == STREAM};
         pend_pad_r <= {pend_pad_r[0], pad_row};
      end
   end

   // every padded pixel goes over the link as a real one
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         px_valid_r <= 1'b0;
         px_data_r <= '0;
         pps_valid_r <= 1'b0;
      end else begin
         px_valid_r <= pend_r[1];
         px_data_r <= pend_pad_r[1] ? midpoint : PIX_DATA_I;
         pps_valid_r <= (state_r == IDLE) & start_r & (err_c == '0);
      end
   end

   assign link.picture_parameter_set = pps_r;
   assign link.pps_valid = pps_valid_r;
   assign link.px_valid = px_valid_r;
   assign link.px_data = px_data_r;

   // ****************************************
   // status
   // ****************************************
   always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         done_r <= 1'b0;
         lerr_r <= 1'b0;
         nak_r <= 1'b0;
         code_r <= '0;
      end else if (start_r && state_r == IDLE) begin
         done_r <= 1'b0;
         lerr_r <= err_c != '0;
         nak_r <= 1'b0;
         code_r <= err_c;
      end else begin
         if (state_r == STREAM && pic_end) done_r <= 1'b1;
         if (state_r == WAIT && link.pps_nak) nak_r <= 1'b1;
      end
   end
endmodule : sgp_enc
